/* File: hdl/dsc_cfg.svh */
// Timing counts and field positions for the dual-slope sequencer and display driver
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH
`define DSC_OSC_DIV        4
`define DSC_INT_COUNTS     1000
`define DSC_DEINT_MAX      2000
`define DSC_CYCLE_COUNTS   4000
`define DSC_PLATE_DIV      800
`define DSC_PLATE_HALF     (`DSC_PLATE_DIV / 2)
`define DSC_OSC_HZ         48000
`define DSC_SEG_A          0
`define DSC_SEG_G          6
`endif

/* File: hdl/dsc_pkg.sv */
// Types shared by the dual-slope sequencer files
package dsc_pkg;
	typedef enum logic [1:0] {
		DSC_AUTOZERO = 2'b00,
		DSC_INTEG    = 2'b01,
		DSC_RAMPDOWN = 2'b10
	} dsc_phase_t;

	typedef struct packed {
		logic isolate_pins;
		logic short_to_common;
		logic charge_reference;
		logic offset_loop_close;
		logic connect_pins;
		logic low_to_common;
		logic reference_across_high;
		logic reference_negative;
	} dsc_switch_t;

	typedef struct packed {
		logic [6:0] units;
		logic [6:0] tens;
		logic [6:0] hundreds;
		logic       thousands_one_segment;
		logic       minus_sign_segment;
	} dsc_segments_t;
endpackage : dsc_pkg

/* File: hdl/dsc_seg_decode.sv */
// Combinational BCD to seven-segment decoder, bit 0 is segment A
`timescale 1ns/1ns
module dsc_seg_decode
	import dsc_pkg::*;
(
	input  wire logic [3:0] digit_in,
	input  wire logic       blank_in,
	output logic      [6:0] seg_out
);
	always_comb begin
		unique case (digit_in)
			4'h0: seg_out = 7'h3f;
			4'h1: seg_out = 7'h06;
			4'h2: seg_out = 7'h5b;
			4'h3: seg_out = 7'h4f;
			4'h4: seg_out = 7'h66;
			4'h5: seg_out = 7'h6d;
			4'h6: seg_out = 7'h7d;
			4'h7: seg_out = 7'h07;
			4'h8: seg_out = 7'h7f;
			4'h9: seg_out = 7'h6f;
			default: seg_out = 7'h00;
		endcase
		if (blank_in) begin
			seg_out = 7'h00;
		end
	end
endmodule : dsc_seg_decode

/* File: hdl/dsc_sequencer.sv */
// Dual-slope converter sequencer, decade counter and static LCD drive
`timescale 1ns/1ns
`include "dsc_cfg.svh"
module dsc_sequencer
	import dsc_pkg::*;
#(
	parameter int INT_COUNTS   = `DSC_INT_COUNTS,
	parameter int DEINT_MAX    = `DSC_DEINT_MAX,
	parameter int CYCLE_COUNTS = `DSC_CYCLE_COUNTS,
	parameter int PLATE_HALF   = `DSC_PLATE_HALF
)(
	input  wire logic          ref_clk_in,
	input  wire logic          srst_in,
	input  wire logic          comparator_in,
	input  wire logic          lamp_test_in,
	output dsc_switch_t        switch_out,
	output dsc_phase_t         phase_out,
	output dsc_segments_t      segments_out,
	output logic               common_plate_drive_out
);
	localparam int OSC_DIV = `DSC_OSC_DIV;

	// Comparator and lamp-test inputs pass two flops; first stage read only by second
	logic comp_meta, comp_sync, lamp_meta, lamp_sync;
	always_ff @(posedge ref_clk_in) begin
		comp_meta <= comparator_in;
		comp_sync <= comp_meta;
		lamp_meta <= lamp_test_in;
		lamp_sync <= lamp_meta;
	end

	// Count-clock enable, oscillator over four
	logic [1:0] pre_cnt, next_pre_cnt;
	logic       count_en;
	always_comb begin
		next_pre_cnt = pre_cnt + 2'h1;
		if (pre_cnt == 2'(OSC_DIV - 1)) begin
			next_pre_cnt = 2'h0;
		end
		if (srst_in) begin
			next_pre_cnt = 2'h0;
		end
	end
	assign count_en = (pre_cnt == 2'(OSC_DIV - 1));
	always_ff @(posedge ref_clk_in) begin
		pre_cnt <= next_pre_cnt;
	end

	// Phase machine state
	dsc_phase_t  phase, next_phase;
	logic [11:0] cycle_cnt, next_cycle_cnt;
	logic [11:0] phase_cnt, next_phase_cnt;
	logic        polarity_neg, next_polarity_neg;

	// Reading kept as decade counter so no binary to BCD step
	function automatic logic [15:0] bcd_inc(input logic [15:0] v);
		logic [15:0] r;
		logic        carry;
		r = v;
		carry = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (carry) begin
				if (r[4*i +: 4] == 4'h9) begin
					r[4*i +: 4] = 4'h0;
				end else begin
					r[4*i +: 4] = r[4*i +: 4] + 4'h1;
					carry = 1'b0;
				end
			end
		end
		return r;
	endfunction : bcd_inc

	logic [15:0] count_bcd, next_count_bcd;
	logic [15:0] shown_bcd, next_shown_bcd;
	logic        overrange, next_overrange;
	logic        end_rampdown;

	always_comb begin
		next_phase        = phase;
		next_cycle_cnt    = cycle_cnt;
		next_phase_cnt    = phase_cnt;
		next_polarity_neg = polarity_neg;
		next_count_bcd    = count_bcd;
		next_shown_bcd    = shown_bcd;
		next_overrange    = overrange;
		end_rampdown      = 1'b0;
		if (count_en) begin
			next_cycle_cnt = cycle_cnt + 12'h1;
			next_phase_cnt = phase_cnt + 12'h1;
			unique case (phase)
				DSC_AUTOZERO: begin
					// Auto-zero absorbs the rest so total stays fixed
					if (cycle_cnt == 12'(CYCLE_COUNTS - 1)) begin
						next_phase     = DSC_INTEG;
						next_cycle_cnt = 12'h0;
						next_phase_cnt = 12'h0;
					end
				end
				DSC_INTEG: begin
					if (phase_cnt == 12'(INT_COUNTS - 1)) begin
						next_phase        = DSC_RAMPDOWN;
						next_phase_cnt    = 12'h0;
						next_polarity_neg = comp_sync;
						next_count_bcd    = 16'h0000;
					end
				end
				DSC_RAMPDOWN: begin
					// Comparator reads high while integrator has not crossed
					if (!comp_sync) begin
						end_rampdown   = 1'b1;
						next_overrange = 1'b0;
					end else if (phase_cnt == 12'(DEINT_MAX - 1)) begin
						end_rampdown   = 1'b1;
						next_overrange = 1'b1;
					end else begin
						next_count_bcd = bcd_inc(count_bcd);
					end
					if (end_rampdown) begin
						next_phase     = DSC_AUTOZERO;
						next_phase_cnt = 12'h0;
						next_shown_bcd = count_bcd;
					end
				end
			endcase
		end
		if (srst_in) begin
			next_phase        = DSC_AUTOZERO;
			next_cycle_cnt    = 12'h0;
			next_phase_cnt    = 12'h0;
			next_polarity_neg = 1'b0;
			next_count_bcd    = 16'h0000;
			next_shown_bcd    = 16'h0000;
			next_overrange    = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		phase        <= next_phase;
		cycle_cnt    <= next_cycle_cnt;
		phase_cnt    <= next_phase_cnt;
		polarity_neg <= next_polarity_neg;
		count_bcd    <= next_count_bcd;
		shown_bcd    <= next_shown_bcd;
		overrange    <= next_overrange;
	end

	// Switch controls follow the phase
	dsc_switch_t next_switch;
	always_comb begin
		next_switch = '0;
		unique case (next_phase)
			DSC_AUTOZERO: begin
				next_switch.isolate_pins      = 1'b1;
				next_switch.short_to_common   = 1'b1;
				next_switch.charge_reference  = 1'b1;
				next_switch.offset_loop_close = 1'b1;
			end
			DSC_INTEG: begin
				next_switch.connect_pins = 1'b1;
			end
			DSC_RAMPDOWN: begin
				next_switch.low_to_common         = 1'b1;
				next_switch.reference_across_high = 1'b1;
				next_switch.reference_negative    = ~next_polarity_neg;
			end
		endcase
	end

	// Plate drive divider, oscillator over 800
	logic [8:0] plate_cnt, next_plate_cnt;
	logic       plate, next_plate;
	always_comb begin
		next_plate_cnt = plate_cnt + 9'h1;
		next_plate     = plate;
		if (plate_cnt == 9'(PLATE_HALF - 1)) begin
			next_plate_cnt = 9'h0;
			next_plate     = ~plate;
		end
		if (srst_in) begin
			next_plate_cnt = 9'h0;
			next_plate     = 1'b0;
		end
	end
	always_ff @(posedge ref_clk_in) begin
		plate_cnt <= next_plate_cnt;
		plate     <= next_plate;
	end

	// Segment patterns from held reading
	logic [6:0] seg_lvl [3];
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_digit
			dsc_seg_decode u_dec (
				.digit_in (shown_bcd[4*g +: 4]),
				.blank_in (overrange),
				.seg_out  (seg_lvl[g])
			);
		end
	endgenerate

	// Lamp test holds constant levels; can harm panel if left on
	dsc_segments_t on_lvl, next_segments;
	always_comb begin
		on_lvl.units                 = seg_lvl[0];
		on_lvl.tens                  = seg_lvl[1];
		on_lvl.hundreds              = seg_lvl[2];
		on_lvl.thousands_one_segment = overrange | (shown_bcd[15:12] != 4'h0);
		on_lvl.minus_sign_segment    = polarity_neg;
		if (lamp_sync) begin
			next_segments = '1;
		end else begin
			next_segments = on_lvl ^ {$bits(dsc_segments_t){next_plate}};
		end
		if (srst_in) begin
			next_segments = '0;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		segments_out           <= next_segments;
		switch_out             <= srst_in ? '0 : next_switch;
		phase_out              <= next_phase;
		common_plate_drive_out <= next_plate;
	end
endmodule : dsc_sequencer

/* File: tb/dsc_seq_chk.sv */
// Concurrent checks on the sequencer ports
`timescale 1ns/1ns
module dsc_seq_chk
	import dsc_pkg::*;
#(
	parameter int INT_COUNTS   = 10,
	parameter int DEINT_MAX    = 20,
	parameter int CYCLE_COUNTS = 40,
	parameter int PLATE_HALF   = 4
)(
	input wire logic          ref_clk_in,
	input wire logic          srst_in,
	input wire logic          comparator_in,
	input wire logic          lamp_test_in,
	input wire dsc_switch_t   switch_out,
	input wire dsc_phase_t    phase_out,
	input wire dsc_segments_t segments_out,
	input wire logic          common_plate_drive_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (srst_in);
	dsc_phase_t lp;
	logic       lpl;
	logic       pseen;
	logic       cseen;
	int         pc;
	int         ph;
	int         cy;
	wire        ent = phase_out == DSC_INTEG && lp != DSC_INTEG;
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			lp    <= DSC_AUTOZERO;
			lpl   <= 1'b0;
			pseen <= 1'b0;
			cseen <= 1'b0;
		end else begin
			lp    <= phase_out;
			lpl   <= common_plate_drive_out;
			pc    <= (common_plate_drive_out != lpl) ? 1 : pc + 1;
			ph    <= (phase_out != lp) ? 1 : ph + 1;
			cy    <= ent ? 1 : cy + 1;
			pseen <= pseen | (common_plate_drive_out != lpl);
			cseen <= cseen | ent;
		end
	end
	phase_order_a: assert property (phase_out != lp |-> phase_out ==
		((lp == DSC_RAMPDOWN) ? DSC_AUTOZERO : dsc_phase_t'(lp + 2'b01)))
		else $error("phase order broken");
	autozero_sw_a: assert property (phase_out == DSC_AUTOZERO && !$past(srst_in)
		|-> switch_out == 8'hf0) else $error("autozero switches wrong");
	integ_sw_a: assert property (phase_out == DSC_INTEG |-> switch_out == 8'h08)
		else $error("integrate switches wrong");
	ramp_sw_a: assert property (phase_out == DSC_RAMPDOWN |-> switch_out[7:1] == 7'h03)
		else $error("ramp-down switches wrong");
	ref_polarity_a: assert property (phase_out == DSC_AUTOZERO && lp == DSC_RAMPDOWN
		&& !lamp_test_in |=> !$stable(common_plate_drive_out) || (common_plate_drive_out
		^ segments_out.minus_sign_segment) == !$past(switch_out.reference_negative, 2))
		else $error("reference polarity not opposite to sign");
	plate_period_a: assert property (common_plate_drive_out != lpl && pseen
		|-> pc == PLATE_HALF) else $error("plate half period wrong");
	integ_len_a: assert property (phase_out != lp && lp == DSC_INTEG
		|-> ph == 4 * INT_COUNTS) else $error("integrate length wrong");
	cycle_len_a: assert property (ent && cseen |-> cy == 4 * CYCLE_COUNTS)
		else $error("cycle length wrong");
	lamp_all_a: assert property (lamp_test_in [*4] |=> segments_out == 23'h7fffff)
		else $error("lamp test not all on");
endmodule : dsc_seq_chk
bind dsc_sequencer dsc_seq_chk #(.INT_COUNTS(INT_COUNTS), .DEINT_MAX(DEINT_MAX),
	.CYCLE_COUNTS(CYCLE_COUNTS), .PLATE_HALF(PLATE_HALF)) dsc_seq_chk_i (.ref_clk_in,
	.srst_in, .comparator_in, .lamp_test_in, .switch_out, .phase_out, .segments_out,
	.common_plate_drive_out);

/* File: tb/dsc_front_model.sv */
// Integrator and comparator model driven by a target ramp-down count
`timescale 1ns/1ns
module dsc_front_model
	import dsc_pkg::*;
(
	input  wire logic       ref_clk_in,
	input  wire dsc_phase_t phase_in,
	input  wire logic [9:0] count_in,
	input  wire logic       negative_in,
	output logic            comparator_out
);
	int ramp = 0;
	always @(posedge ref_clk_in) begin
		if (phase_in == DSC_RAMPDOWN) begin
			// Crossing placed on the edge that ends a count enable, so sync delay cannot shift it
			ramp           <= ramp + 1;
			comparator_out <= (ramp + 1) < 4 * int'(count_in);
		end else begin
			ramp           <= 0;
			comparator_out <= negative_in;
		end
	end
endmodule : dsc_front_model

/* File: tb/dual_slope_adc_sequencer_lcd_drive_tb_top.sv */
// Self-checking bench for the dual-slope sequencer
`timescale 1ns/1ns
module dual_slope_adc_sequencer_lcd_drive_tb_top
	import dsc_pkg::*;
;
	logic          ref_clk_in = 1'b0;
	logic          srst_in = 1'b1;
	logic          lamp_test_in = 1'b0;
	logic          negative = 1'b0;
	logic [9:0]    target = 10'h0;
	logic [31:0]   lfsr = 32'h6793;
	logic          comparator_in;
	logic          common_plate_drive_out;
	dsc_switch_t   switch_out;
	dsc_phase_t    phase_out;
	dsc_segments_t segments_out;
	int            bad_count = 0;
	int            checks_done = 0;
	int            cycles = 0;
	dsc_sequencer #(.INT_COUNTS(100), .DEINT_MAX(200), .CYCLE_COUNTS(400), .PLATE_HALF(8))
		dsc_sequencer_i (.ref_clk_in, .srst_in, .comparator_in, .lamp_test_in, .switch_out,
		.phase_out, .segments_out, .common_plate_drive_out);
	dsc_front_model dsc_front_model_i (.ref_clk_in, .phase_in(phase_out), .count_in(target),
		.negative_in(negative), .comparator_out(comparator_in));
	initial forever #10 ref_clk_in = ~ref_clk_in;
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	always @(posedge ref_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			bad_count++;
			test_done();
		end
	end
	function automatic logic [6:0] seg7(input int d);
		logic [6:0] t [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
		return t[d];
	endfunction : seg7
	function automatic logic [22:0] want_seg(input int n, input logic neg);
		if (n >= 200)
			return {21'h0, 1'b1, neg};
		return {seg7(n % 10), seg7(n / 10 % 10), seg7(n / 100), 1'b0, neg};
	endfunction : want_seg
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, want, seen);
		end
	endtask : check
	task automatic wait_phase(input dsc_phase_t p, output int n);
		n = 0;
		while (phase_out !== p && n < 5000) begin
			@(posedge ref_clk_in);
			#1;
			n++;
		end
	endtask : wait_phase
	task automatic convert(input int n, input logic neg);
		int w;
		@(posedge ref_clk_in);
		target   <= n[9:0];
		negative <= neg;
		#1;
		wait_phase(DSC_RAMPDOWN, w);
		wait_phase(DSC_INTEG, w);
		check("ramp plus autozero span", w, 1200);
		// Sample away from a plate edge so segment and plate registers agree
		@(common_plate_drive_out);
		repeat (2) @(posedge ref_clk_in);
		#1;
		check("segments", segments_out ^ {23{common_plate_drive_out}}, want_seg(n, neg));
	endtask : convert
	initial begin
		repeat (6) @(posedge ref_clk_in);
		srst_in      <= 1'b0;
		lamp_test_in <= 1'b1;
		repeat (6) @(posedge ref_clk_in);
		#1;
		check("lamp test", segments_out, 23'h7fffff);
		@(posedge ref_clk_in);
		lamp_test_in <= 1'b0;
		convert(0, 1'b0);
		convert(199, 1'b0);
		convert(100, 1'b1);
		convert(250, 1'b0);
		repeat (6) begin
			lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
			convert(int'(lfsr[15:0]) % 200, lfsr[7]);
		end
		test_done();
	end
endmodule : dual_slope_adc_sequencer_lcd_drive_tb_top
